// ### rtl/chan_ctrl_pkg.sv
// Constants for the channel enable and loopback block
package chan_ctrl_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int Q_DEPTH = 4;
  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_STAT = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_TXDATA = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_RXDATA = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_BUF = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_PTRS = 3'h5;
  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LOOP_BIT = 1;
  localparam int STICKY_W = 3;
  localparam int ST_DONE = 0;
  localparam int ST_TXOVF = 1;
  localparam int ST_RXOVR = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_TXEMPTY = 4;
  localparam int ST_RXEMPTY = 5;
  ////////////////////////////////////////////////////////////////////////
  // Reset and idle values
  localparam logic EN_RST = 1'h0;
  localparam logic LOOP_RST = 1'h0;
  localparam logic IDLE_LEVEL = 1'h1;
endpackage : chan_ctrl_pkg

// ### rtl/word_queue.sv
// Small word queue with visible read and write pointers
`timescale 1ns/10ps
module word_queue #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic [W-1:0] push_data_i,
  input wire logic pop_i,
  output logic [W-1:0] data_o,
  output logic empty_o,
  output logic full_o,
  output logic [$clog2(DEPTH)-1:0] wp_o,
  output logic [$clog2(DEPTH)-1:0] rp_o
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } q_s;
  q_s st;
  q_s next_st;
  logic do_push;
  logic do_pop;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    do_push = push_i && !full_o;
    do_pop = pop_i && !empty_o;
    if (clear_i) begin
      next_st = '0;
    end else begin
      if (do_push) begin
        next_st.mem[st.wp] = push_data_i;
        next_st.wp = st.wp + PW'(1);
      end
      if (do_pop) begin
        next_st.rp = st.rp + PW'(1);
      end
      next_st.cnt = st.cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign data_o = st.mem[st.rp];
  assign empty_o = (st.cnt == '0);
  assign full_o = (st.cnt == (PW+1)'(DEPTH));
  assign wp_o = st.wp;
  assign rp_o = st.rp;
endmodule : word_queue

// ### rtl/bus_channel_enable_loopback.sv
// One bus channel with enable, disable flush and internal loopback
// Notes on behaviour
// - Disabled channel tri-states its bus drivers.
// - Disable clears buffer, status, queue pointers.
// - Disable stops any running frame at once.
// - Loop mode feeds transmitter into receiver internally.
// - Loop mode cuts external bus off completely.
// - Loop entry clears enable, buffer, status, queues.
// - Loop exit restores reset values and queues.
// - Queues advance in loop as normally.
// - Reset clears enable, tri-stating the bus.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module bus_channel_enable_loopback #(
  parameter int W = chan_ctrl_pkg::DATA_W,
  parameter int DEPTH = chan_ctrl_pkg::Q_DEPTH
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [chan_ctrl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [W-1:0] rdata_o,
  input wire logic bus_rx_i,
  output logic bus_tx_o,
  output logic bus_oe_o
);
  localparam int CW = $clog2(W);
  localparam int PW = $clog2(DEPTH);
  typedef enum logic {IDLE, SHIFT} fsm_e;
  typedef struct packed {
    logic en;
    logic loop;
    logic [chan_ctrl_pkg::STICKY_W-1:0] sticky;
    logic [W-1:0] buffer;
    fsm_e fsm;
    logic [CW-1:0] cnt;
    logic [W-1:0] txsh;
    logic [W-1:0] rxsh;
    logic line_bit;
    logic pin_tx;
    logic pin_oe;
    logic [W-1:0] rdata;
  } chan_s;
  chan_s st;
  chan_s next_st;
  logic flush;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic rx_in;
  logic [W-1:0] rx_word;
  logic [W-1:0] tx_head;
  logic [W-1:0] rx_head;
  logic tx_empty;
  logic tx_full;
  logic rx_empty;
  logic rx_full;
  logic [PW-1:0] tx_wp;
  logic [PW-1:0] tx_rp;
  logic [PW-1:0] rx_wp;
  logic [PW-1:0] rx_rp;
  logic ctrl_wr;
  logic [chan_ctrl_pkg::STICKY_W-1:0] set_ev;
  logic [chan_ctrl_pkg::STICKY_W-1:0] clr_ev;

  // Sticky flag update, set beats clear
  function automatic logic [chan_ctrl_pkg::STICKY_W-1:0] sticky_upd(
    input logic [chan_ctrl_pkg::STICKY_W-1:0] old,
    input logic [chan_ctrl_pkg::STICKY_W-1:0] set,
    input logic [chan_ctrl_pkg::STICKY_W-1:0] clr
  );
    sticky_upd = (old & ~clr) | set;
  endfunction : sticky_upd

  ////////////////////////////////////////////////////////////////////////
  // Queues
  word_queue #(.W(W), .DEPTH(DEPTH)) u_txq (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .clear_i(flush), .push_i(tx_push), .push_data_i(wdata_i),
    .pop_i(tx_pop), .data_o(tx_head), .empty_o(tx_empty),
    .full_o(tx_full), .wp_o(tx_wp), .rp_o(tx_rp)
  );
  word_queue #(.W(W), .DEPTH(DEPTH)) u_rxq (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .clear_i(flush), .push_i(rx_push), .push_data_i(rx_word),
    .pop_i(rx_pop), .data_o(rx_head), .empty_o(rx_empty),
    .full_o(rx_full), .wp_o(rx_wp), .rp_o(rx_rp)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control and frame engine
  always_comb begin
    next_st = st;
    ctrl_wr = wr_i && (addr_i == chan_ctrl_pkg::OFF_CTRL);
    flush = 1'h0;
    if (ctrl_wr) begin
      if (wdata_i[chan_ctrl_pkg::CTRL_LOOP_BIT] != st.loop) begin
        next_st.en = 1'h0;
        next_st.loop = wdata_i[chan_ctrl_pkg::CTRL_LOOP_BIT];
        flush = 1'h1;
      end else if (!st.loop) begin
        next_st.en = wdata_i[chan_ctrl_pkg::CTRL_EN_BIT];
        flush = st.en && !wdata_i[chan_ctrl_pkg::CTRL_EN_BIT];
      end
    end
    // In loop mode the transmit line_bit, not bus_rx_i, feeds the receiver
    rx_in = st.loop ? st.line_bit : bus_rx_i;
    rx_word = {st.rxsh[W-2:0], rx_in};
    tx_push = wr_i && (addr_i == chan_ctrl_pkg::OFF_TXDATA) && !flush;
    rx_pop = rd_i && (addr_i == chan_ctrl_pkg::OFF_RXDATA) && !flush;
    tx_pop = (st.fsm == IDLE) && (st.en || st.loop) && !tx_empty
      && !flush;
    rx_push = 1'h0;
    set_ev = '0;
    set_ev[chan_ctrl_pkg::ST_TXOVF] = tx_push && tx_full;
    case (st.fsm)
      IDLE: begin
        next_st.line_bit = chan_ctrl_pkg::IDLE_LEVEL;
        if (tx_pop) begin
          next_st.fsm = SHIFT;
          next_st.cnt = '0;
          next_st.line_bit = tx_head[W-1];
          next_st.txsh = {tx_head[W-2:0], 1'h0};
        end
      end
      SHIFT: begin
        next_st.rxsh = rx_word;
        next_st.line_bit = st.txsh[W-1];
        next_st.txsh = {st.txsh[W-2:0], 1'h0};
        next_st.cnt = st.cnt + CW'(1);
        if (st.cnt == CW'(W - 1)) begin
          next_st.fsm = IDLE;
          next_st.line_bit = chan_ctrl_pkg::IDLE_LEVEL;
          next_st.buffer = rx_word;
          rx_push = !flush && !rx_full;
          set_ev[chan_ctrl_pkg::ST_DONE] = 1'h1;
          set_ev[chan_ctrl_pkg::ST_RXOVR] = rx_full;
        end
      end
      default: begin
        next_st.fsm = IDLE;
      end
    endcase
    clr_ev = '0;
    if (wr_i && (addr_i == chan_ctrl_pkg::OFF_STAT)) begin
      clr_ev = wdata_i[chan_ctrl_pkg::STICKY_W-1:0];
    end
    next_st.sticky = sticky_upd(st.sticky, set_ev, clr_ev);
    if (flush) begin
      next_st.sticky = '0;
      next_st.buffer = '0;
      next_st.fsm = IDLE;
      next_st.cnt = '0;
      next_st.txsh = '0;
      next_st.rxsh = '0;
      next_st.line_bit = chan_ctrl_pkg::IDLE_LEVEL;
    end
    next_st.pin_oe = next_st.en && !next_st.loop;
    next_st.pin_tx = next_st.pin_oe && next_st.line_bit;
    next_st.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        chan_ctrl_pkg::OFF_CTRL: begin
          next_st.rdata[chan_ctrl_pkg::CTRL_EN_BIT] = st.en;
          next_st.rdata[chan_ctrl_pkg::CTRL_LOOP_BIT] = st.loop;
        end
        chan_ctrl_pkg::OFF_STAT: begin
          next_st.rdata[chan_ctrl_pkg::STICKY_W-1:0] = st.sticky;
          next_st.rdata[chan_ctrl_pkg::ST_BUSY] = (st.fsm == SHIFT);
          next_st.rdata[chan_ctrl_pkg::ST_TXEMPTY] = tx_empty;
          next_st.rdata[chan_ctrl_pkg::ST_RXEMPTY] = rx_empty;
        end
        chan_ctrl_pkg::OFF_RXDATA: begin
          next_st.rdata = rx_empty ? '0 : rx_head;
        end
        chan_ctrl_pkg::OFF_BUF: begin
          next_st.rdata = st.buffer;
        end
        chan_ctrl_pkg::OFF_PTRS: begin
          next_st.rdata = W'({rx_wp, rx_rp, tx_wp, tx_rp});
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
      st.en <= chan_ctrl_pkg::EN_RST;
      st.loop <= chan_ctrl_pkg::LOOP_RST;
      st.line_bit <= chan_ctrl_pkg::IDLE_LEVEL;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign bus_tx_o = st.pin_tx;
  assign bus_oe_o = st.pin_oe;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_oe_off_disabled: assert property (!st.en |-> !bus_oe_o)
    else $error("bus driven while channel disabled");
  a_disable_flush: assert property (
    $fell(st.en) && !st.loop |-> tx_empty && rx_empty
      && st.sticky == '0 && st.buffer == '0)
    else $error("disable left buffer, status or queues");
  a_disable_stops: assert property (
    ce_i && st.fsm == SHIFT && ctrl_wr && flush |=> st.fsm == IDLE)
    else $error("frame kept running after disable");
  a_loop_path: assert property (
    ce_i && st.loop && st.fsm == SHIFT && !flush
      |=> st.rxsh[0] == $past(st.line_bit))
    else $error("loop receiver did not see transmit bit");
  a_loop_isolated: assert property (
    st.loop |-> !bus_oe_o && !bus_tx_o)
    else $error("bus not isolated in loop mode");
  a_loop_entry: assert property (
    $rose(st.loop) |-> !st.en && tx_empty && rx_empty
      && st.sticky == '0 && st.buffer == '0 && st.fsm == IDLE)
    else $error("loop entry did not clear channel");
  a_loop_exit: assert property (
    $fell(st.loop) |-> !st.en && tx_empty && rx_empty
      && st.sticky == '0 && st.buffer == '0 && st.fsm == IDLE)
    else $error("loop exit did not restore reset state");
  a_loop_queue: assert property (
    ce_i && st.loop && st.fsm == IDLE && !tx_empty && !flush
      |=> st.fsm == SHIFT && tx_rp != $past(tx_rp))
    else $error("loop mode did not start queued frame");
  a_reset_off: assert property (
    $rose(arst_n_i) |-> !st.en && !st.loop && !bus_oe_o && !bus_tx_o)
    else $error("channel enabled after reset");

  c_loop_frame: cover property (
    st.loop && st.sticky[chan_ctrl_pkg::ST_DONE]);
  c_disable_mid: cover property (st.fsm == SHIFT && flush && st.en);
  c_rx_overrun: cover property (st.sticky[chan_ctrl_pkg::ST_RXOVR]);
endmodule : bus_channel_enable_loopback

// ### bench/slave_node.sv
// Remote slave node model at the far side of the bus
`timescale 1ns/10ps
module slave_node (
  input wire logic mclk_i,
  input wire logic bus_tx_i,
  input wire logic bus_oe_i,
  output logic bus_rx_o
);
  logic wobble = 1'h0;
  ////////////////////////////////////////
  // Undriven line shows a changing level
  always_ff @(posedge mclk_i) begin
    wobble <= ~wobble;
  end
  // Echo of the master's level while driven
  assign bus_rx_o = bus_oe_i ? bus_tx_i : wobble;
endmodule : slave_node

// ### bench/tb_bus_channel_enable_loopback.sv
// Self-checking bench for the channel enable and loop block
`timescale 1ns/10ps
module tb_bus_channel_enable_loopback;
  logic mclk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic ce_i = 1'h1;
  logic [15:0] rdata_o;
  logic bus_rx_i;
  logic bus_tx_o;
  logic bus_oe_o;
  int failures = 0;
  int cmp_count = 0;
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  bus_channel_enable_loopback dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .bus_rx_i(bus_rx_i),
    .bus_tx_o(bus_tx_o), .bus_oe_o(bus_oe_o));
  slave_node far (.mclk_i(mclk_i), .bus_tx_i(bus_tx_o),
    .bus_oe_i(bus_oe_o), .bus_rx_o(bus_rx_i));
  ////////////////////////////////////////
  // Bus tasks
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, input string nm,
    input logic [15:0] e);
    @(posedge mclk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'h0;
    #1;
    chk(nm, e, rdata_o);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : idle
  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk("oe", 16'h0, bus_oe_o);
    chk("tx", 16'h0, bus_tx_o);
    rd(chan_ctrl_pkg::OFF_CTRL, "ctrl", 16'h0);
    rd(chan_ctrl_pkg::OFF_PTRS, "ptrs", 16'h0);
  endtask : t_reset
  task automatic t_frame();
    wr(chan_ctrl_pkg::OFF_CTRL, 16'h1);
    chk("oe", 16'h1, bus_oe_o);
    wr(chan_ctrl_pkg::OFF_TXDATA, 16'ha5c3);
    idle(24);
    rd(chan_ctrl_pkg::OFF_BUF, "buf", 16'ha5c3);
    rd(chan_ctrl_pkg::OFF_STAT, "stat", 16'h0011);
    rd(chan_ctrl_pkg::OFF_RXDATA, "rxq", 16'ha5c3);
    rd(chan_ctrl_pkg::OFF_PTRS, "ptrs", 16'h0055);
  endtask : t_frame
  task automatic t_abort();
    wr(chan_ctrl_pkg::OFF_TXDATA, 16'h1234);
    wr(chan_ctrl_pkg::OFF_TXDATA, 16'h5678);
    idle(5);
    wr(chan_ctrl_pkg::OFF_CTRL, 16'h0);
    chk("oe", 16'h0, bus_oe_o);
    chk("tx", 16'h0, bus_tx_o);
    rd(chan_ctrl_pkg::OFF_PTRS, "ptrs", 16'h0);
    rd(chan_ctrl_pkg::OFF_STAT, "stat", 16'h0030);
    idle(30);
    chk("oe", 16'h0, bus_oe_o);
    rd(chan_ctrl_pkg::OFF_BUF, "buf", 16'h0);
  endtask : t_abort
  task automatic t_loop();
    wr(chan_ctrl_pkg::OFF_CTRL, 16'h1);
    wr(chan_ctrl_pkg::OFF_TXDATA, 16'hbeef);
    idle(3);
    wr(chan_ctrl_pkg::OFF_CTRL, 16'h2);
    rd(chan_ctrl_pkg::OFF_CTRL, "ctrl", 16'h2);
    rd(chan_ctrl_pkg::OFF_PTRS, "ptrs", 16'h0);
    rd(chan_ctrl_pkg::OFF_STAT, "stat", 16'h0030);
    wr(chan_ctrl_pkg::OFF_CTRL, 16'h3);
    rd(chan_ctrl_pkg::OFF_CTRL, "ctrl", 16'h2);
    wr(chan_ctrl_pkg::OFF_TXDATA, 16'h3c5a);
    repeat (22) begin
      idle(1);
      chk("oe", 16'h0, bus_oe_o);
      chk("tx", 16'h0, bus_tx_o);
    end
    rd(chan_ctrl_pkg::OFF_BUF, "buf", 16'h3c5a);
    rd(chan_ctrl_pkg::OFF_PTRS, "ptrs", 16'h0045);
    rd(chan_ctrl_pkg::OFF_STAT, "stat", 16'h0011);
  endtask : t_loop
  task automatic t_exit();
    wr(chan_ctrl_pkg::OFF_CTRL, 16'h0);
    rd(chan_ctrl_pkg::OFF_CTRL, "ctrl", 16'h0);
    rd(chan_ctrl_pkg::OFF_PTRS, "ptrs", 16'h0);
    rd(chan_ctrl_pkg::OFF_BUF, "buf", 16'h0);
    rd(chan_ctrl_pkg::OFF_STAT, "stat", 16'h0030);
    wr(chan_ctrl_pkg::OFF_CTRL, 16'h1);
    chk("oe", 16'h1, bus_oe_o);
    chk("tx", 16'h1, bus_tx_o);
  endtask : t_exit
  task automatic t_freeze();
    @(posedge mclk_i);
    ce_i <= 1'h0;
    wr(chan_ctrl_pkg::OFF_CTRL, 16'h0);
    @(posedge mclk_i);
    ce_i <= 1'h1;
    #1;
    chk("oe", 16'h1, bus_oe_o);
    rd(chan_ctrl_pkg::OFF_CTRL, "ctrl", 16'h1);
  endtask : t_freeze
  task automatic t_rst_mid();
    @(posedge mclk_i);
    arst_n_i <= 1'h0;
    idle(3);
    chk("oe", 16'h0, bus_oe_o);
    chk("tx", 16'h0, bus_tx_o);
    @(posedge mclk_i);
    arst_n_i <= 1'h1;
    #1;
    chk("oe", 16'h0, bus_oe_o);
    rd(chan_ctrl_pkg::OFF_CTRL, "ctrl", 16'h0);
    rd(chan_ctrl_pkg::OFF_STAT, "stat", 16'h0030);
  endtask : t_rst_mid
  ////////////////////////////////////////
  // Verdict and main sequence
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'h1;
    #1;
    t_reset();
    t_frame();
    t_abort();
    t_loop();
    t_exit();
    t_freeze();
    t_rst_mid();
    end_sim();
  end
endmodule : tb_bus_channel_enable_loopback
